//--- shared/adcrc_pkg.sv
// Package: register map, field layout, codes and types of the ADC result/compute control
package adcrc_pkg;
   localparam int unsigned RES_W  = 12;
   localparam int unsigned SUM_W  = 20;
   localparam int unsigned FILT_W = 16;
   localparam int unsigned CNT_W  = 8;
   localparam int unsigned AXI_AW = 12;
   localparam int unsigned INT_W  = 3;

   // Register indices; the byte address is four times the index
   localparam logic [9:0] IDX_CTRL0    = 10'h110;
   localparam logic [9:0] IDX_RESULT   = 10'h111;
   localparam logic [9:0] IDX_SUM      = 10'h112;
   localparam logic [9:0] IDX_CTRL2    = 10'h113;
   localparam logic [9:0] IDX_PREV     = 10'h114;
   localparam logic [9:0] IDX_FILTER   = 10'h115;
   localparam logic [9:0] IDX_REPEAT   = 10'h116;
   localparam logic [9:0] IDX_STATUS   = 10'h117;
   localparam logic [9:0] IDX_INT_STAT = 10'h118;
   localparam logic [9:0] IDX_INT_EN   = 10'h119;
   localparam logic [9:0] IDX_INT_CLR  = 10'h11A;

   // Control register zero bit positions
   localparam int unsigned CTRL0_ENABLE_BIT  = 0;
   localparam int unsigned CTRL0_GO_BIT      = 1;
   localparam int unsigned CTRL0_JUSTIFY_BIT = 2;
   localparam int unsigned CTRL0_CONT_BIT    = 3;

   // Interrupt status bit positions
   localparam int unsigned INT_DONE_BIT = 0;
   localparam int unsigned INT_CALC_BIT = 1;
   localparam int unsigned INT_OVF_BIT  = 2;

   // Reset values
   localparam logic [7:0]       CTRL0_RESET  = 8'h00;
   localparam logic [7:0]       CTRL2_RESET  = 8'h00;
   localparam logic [CNT_W-1:0] REPEAT_RESET = 8'h01;

   // Operating mode codes
   localparam logic [2:0] MODE_BASIC = 3'h0;
   localparam logic [2:0] MODE_ACCUM = 3'h1;
   localparam logic [2:0] MODE_AVG   = 3'h2;
   localparam logic [2:0] MODE_BURST = 3'h3;
   localparam logic [2:0] MODE_LPF   = 3'h4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Layout of adc_control_two, bit 7 down to bit 0
   typedef struct packed {
      logic       previous_source_select;
      logic [2:0] sum_shift_select;
      logic       sum_clear_command;
      logic [2:0] operating_mode_select;
   } adcrc_ctrl2_t;

   typedef enum {ST_IDLE, ST_BUSY} adcrc_state_t;
endpackage : adcrc_pkg

//--- verilog/adcrc_top.sv
// Design: ADC result formatting, conversion start and computation control with AXI4-Lite
//
// Overview of operation
// - Result reads left or right justified by the result justify select bit.
// - Software result writes store right justified; left format reads them shifted four.
// - Conversions start only while the enable bit is one.
// - Conversion starts on go bit, external trigger, or continuous retrigger.
// - At conversion start, previous sample takes filter value or result per select bit.
// - Filter mode uses time constant two to the shift value, unity gain.
// - Accumulating modes right-shift the sum by the shift value for the computed result.
// - Basic mode ignores the shift field entirely.
// - Writing clear command clears sum, overflow flag and sample counter; bit reads zero after.
// - Mode codes: 001 accumulate, 010 average, 011 burst, 100 filter; 101-111 reserved.
// - Hardware clears the clear command bit when clearing finishes.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

module adcrc_top
   import adcrc_pkg::*;
(
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst,
   input  wire logic [AXI_AW-1:0] i_awaddr,
   input  wire logic              i_awvalid,
   output var  logic              o_awready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   input  wire logic              i_wvalid,
   output var  logic              o_wready,
   output var  logic [1:0]        o_bresp,
   output var  logic              o_bvalid,
   input  wire logic              i_bready,
   input  wire logic [AXI_AW-1:0] i_araddr,
   input  wire logic              i_arvalid,
   output var  logic              o_arready,
   output var  logic [31:0]       o_rdata,
   output var  logic [1:0]        o_rresp,
   output var  logic              o_rvalid,
   input  wire logic              i_rready,
   input  wire logic              i_ext_trigger,
   input  wire logic              i_conv_done,
   input  wire logic [RES_W-1:0]  i_conv_data,
   output var  logic              o_conv_start,
   output var  logic              o_irq
);

   localparam logic [AXI_AW-1:0] A_CTRL0    = {IDX_CTRL0, 2'h0};
   localparam logic [AXI_AW-1:0] A_RESULT   = {IDX_RESULT, 2'h0};
   localparam logic [AXI_AW-1:0] A_SUM      = {IDX_SUM, 2'h0};
   localparam logic [AXI_AW-1:0] A_CTRL2    = {IDX_CTRL2, 2'h0};
   localparam logic [AXI_AW-1:0] A_PREV     = {IDX_PREV, 2'h0};
   localparam logic [AXI_AW-1:0] A_FILTER   = {IDX_FILTER, 2'h0};
   localparam logic [AXI_AW-1:0] A_REPEAT   = {IDX_REPEAT, 2'h0};
   localparam logic [AXI_AW-1:0] A_STATUS   = {IDX_STATUS, 2'h0};
   localparam logic [AXI_AW-1:0] A_INT_STAT = {IDX_INT_STAT, 2'h0};
   localparam logic [AXI_AW-1:0] A_INT_EN   = {IDX_INT_EN, 2'h0};
   localparam logic [AXI_AW-1:0] A_INT_CLR  = {IDX_INT_CLR, 2'h0};

   adcrc_state_t      state_reg;
   adcrc_ctrl2_t      ctrl2_reg;
   adcrc_ctrl2_t      ctrl2_wr;
   logic [7:0]        ctrl0_reg;
   logic [RES_W-1:0]  result_reg;
   logic [FILT_W-1:0] filter_reg;
   logic [FILT_W-1:0] prev_reg;
   logic [SUM_W-1:0]  sum_reg;
   logic              ovf_reg;
   logic [CNT_W-1:0]  count_reg;
   logic [CNT_W-1:0]  repeat_reg;
   logic [INT_W-1:0]  stat_reg;
   logic [INT_W-1:0]  ien_reg;
   logic              burst_more_reg;
   logic [AXI_AW-1:0] awaddr_reg;
   logic              aw_held_reg;
   logic              w_held_reg;
   logic [31:0]       wdata_reg;
   logic [3:0]        wstrb_reg;
   logic [31:0]       wmerge;
   logic              wr_fire;
   logic              wr_ctrl0;
   logic              wr_result;
   logic              wr_ctrl2;
   logic              wr_repeat;
   logic              wr_ien;
   logic              wr_clr;
   logic              wr_hit;
   logic [31:0]       rd_data;
   logic              rd_hit;
   logic              start_fire;
   logic              done_fire;
   logic [2:0]        eff_mode;
   logic [SUM_W:0]    sum_add;
   logic [SUM_W-1:0]  lpf_sum;
   logic [CNT_W-1:0]  count_inc;
   logic [SUM_W-1:0]  sum_next;
   logic [CNT_W-1:0]  count_next;
   logic [FILT_W-1:0] filter_next;
   logic              ovf_set;
   logic              calc_ev;
   logic              burst_ev;
   logic              enable;
   logic              right_just;

   assign enable     = ctrl0_reg[CTRL0_ENABLE_BIT];
   assign right_just = ctrl0_reg[CTRL0_JUSTIFY_BIT];

   // Byte lanes merged over zero; narrow registers keep only their low bits
   assign wmerge = wdata_reg & {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                                {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   assign ctrl2_wr = adcrc_ctrl2_t'(wstrb_reg[0] ? wdata_reg[7:0] : ctrl2_reg);
   assign wr_fire  = aw_held_reg & w_held_reg & ~o_bvalid;

   // AXI4-Lite write channels; address and data accepted in either order
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_awready   <= 1'b1;
         o_wready    <= 1'b1;
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= 32'h00000000;
         wstrb_reg   <= 4'h0;
         o_bvalid    <= 1'b0;
         o_bresp     <= RESP_OKAY;
      end else begin
         if (i_awvalid && o_awready) begin
            awaddr_reg  <= i_awaddr;
            aw_held_reg <= 1'b1;
            o_awready   <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            wdata_reg  <= i_wdata;
            wstrb_reg  <= i_wstrb;
            w_held_reg <= 1'b1;
            o_wready   <= 1'b0;
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            o_bvalid    <= 1'b1;
            o_bresp     <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (o_bvalid && i_bready) begin
            o_bvalid  <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
         end
      end
   end

   always_comb begin
      wr_ctrl0  = 1'b0;
      wr_result = 1'b0;
      wr_ctrl2  = 1'b0;
      wr_repeat = 1'b0;
      wr_ien    = 1'b0;
      wr_clr    = 1'b0;
      wr_hit    = 1'b1;
      if (awaddr_reg == A_CTRL0) begin
         wr_ctrl0 = wr_fire;
      end else if (awaddr_reg == A_RESULT) begin
         wr_result = wr_fire;
      end else if (awaddr_reg == A_CTRL2) begin
         wr_ctrl2 = wr_fire;
      end else if (awaddr_reg == A_REPEAT) begin
         wr_repeat = wr_fire;
      end else if (awaddr_reg == A_INT_EN) begin
         wr_ien = wr_fire;
      end else if (awaddr_reg == A_INT_CLR) begin
         wr_clr = wr_fire;
      end else if (awaddr_reg == A_SUM || awaddr_reg == A_PREV || awaddr_reg == A_FILTER
                   || awaddr_reg == A_STATUS || awaddr_reg == A_INT_STAT) begin
         wr_hit = 1'b1;
      end else begin
         wr_hit = 1'b0;
      end
   end

   // Read decode; left format puts the 12 bits at the top of the low halfword
   always_comb begin
      rd_data = 32'h00000000;
      rd_hit  = 1'b1;
      if (i_araddr == A_CTRL0) begin
         rd_data = {24'h000000, ctrl0_reg};
      end else if (i_araddr == A_RESULT) begin
         rd_data = right_just ? {20'h00000, result_reg}
                              : {16'h0000, result_reg, 4'h0};
      end else if (i_araddr == A_SUM) begin
         rd_data = {ovf_reg, 11'h000, sum_reg};
      end else if (i_araddr == A_CTRL2) begin
         rd_data = {24'h000000, ctrl2_reg};
      end else if (i_araddr == A_PREV) begin
         rd_data = {16'h0000, prev_reg};
      end else if (i_araddr == A_FILTER) begin
         rd_data = {16'h0000, filter_reg};
      end else if (i_araddr == A_REPEAT) begin
         rd_data = {24'h000000, repeat_reg};
      end else if (i_araddr == A_STATUS) begin
         rd_data = {16'h0000, count_reg, 7'h00, state_reg == ST_BUSY};
      end else if (i_araddr == A_INT_STAT) begin
         rd_data = {29'h00000000, stat_reg};
      end else if (i_araddr == A_INT_EN) begin
         rd_data = {29'h00000000, ien_reg};
      end else if (i_araddr == A_INT_CLR) begin
         rd_data = 32'h00000000;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h00000000;
         o_rresp   <= RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b1;
         o_rdata   <= rd_data;
         o_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
         o_rvalid  <= 1'b0;
         o_arready <= 1'b1;
      end
   end

   // Conversion sequencing
   assign start_fire = (state_reg == ST_IDLE) && enable
                       && (ctrl0_reg[CTRL0_GO_BIT] || i_ext_trigger
                           || ctrl0_reg[CTRL0_CONT_BIT] || burst_more_reg);
   assign done_fire  = (state_reg == ST_BUSY) && enable && i_conv_done;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_reg    <= ST_IDLE;
         o_conv_start <= 1'b0;
      end else begin
         o_conv_start <= start_fire;
         case (state_reg)
            ST_IDLE: begin
               if (start_fire) begin
                  state_reg <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               // Dropping enable aborts; a late done from the core is ignored
               if (!enable || i_conv_done) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Go clears on completion; a software set in the same cycle wins
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ctrl0_reg <= CTRL0_RESET;
      end else begin
         if (done_fire || !enable) begin
            ctrl0_reg[CTRL0_GO_BIT] <= 1'b0;
         end
         if (wr_ctrl0 && wstrb_reg[0]) begin
            ctrl0_reg <= {4'h0, wdata_reg[3:0]};
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         result_reg <= '0;
      end else if (done_fire) begin
         result_reg <= i_conv_data;
      end else if (wr_result) begin
         result_reg <= wmerge[RES_W-1:0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         prev_reg <= '0;
      end else if (start_fire) begin
         prev_reg <= ctrl2_reg.previous_source_select ? filter_reg
                                                      : {4'h0, result_reg};
      end
   end

   // Clear command lasts exactly one cycle; a fresh write of one wins
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ctrl2_reg <= adcrc_ctrl2_t'(CTRL2_RESET);
         repeat_reg <= REPEAT_RESET;
      end else begin
         if (ctrl2_reg.sum_clear_command) begin
            ctrl2_reg.sum_clear_command <= 1'b0;
         end
         if (wr_ctrl2) begin
            ctrl2_reg <= ctrl2_wr;
         end
         if (wr_repeat && wstrb_reg[0]) begin
            repeat_reg <= wdata_reg[CNT_W-1:0];
         end
      end
   end

   // Reserved codes fall back to basic so nothing accumulates undefined
   assign eff_mode  = (ctrl2_reg.operating_mode_select > MODE_LPF) ? MODE_BASIC
                      : ctrl2_reg.operating_mode_select;
   assign sum_add   = {1'b0, sum_reg} + (SUM_W + 1)'(i_conv_data);
   assign lpf_sum   = sum_reg - (sum_reg >> ctrl2_reg.sum_shift_select)
                      + SUM_W'(i_conv_data);
   assign count_inc = count_reg + CNT_W'(1);

   always_comb begin
      sum_next    = sum_reg;
      count_next  = count_reg;
      filter_next = filter_reg;
      ovf_set     = 1'b0;
      calc_ev     = 1'b0;
      burst_ev    = 1'b0;
      if (ctrl2_reg.sum_clear_command) begin
         sum_next   = '0;
         count_next = '0;
      end else if (done_fire) begin
         case (eff_mode)
            MODE_ACCUM: begin
               sum_next    = sum_add[SUM_W-1:0];
               ovf_set     = sum_add[SUM_W];
               count_next  = count_inc;
               filter_next = FILT_W'(sum_add >> ctrl2_reg.sum_shift_select);
               calc_ev     = 1'b1;
            end
            MODE_AVG, MODE_BURST: begin
               if (count_inc >= repeat_reg) begin
                  filter_next = FILT_W'(sum_add >> ctrl2_reg.sum_shift_select);
                  sum_next    = '0;
                  count_next  = '0;
                  ovf_set     = sum_add[SUM_W];
                  calc_ev     = 1'b1;
               end else begin
                  sum_next   = sum_add[SUM_W-1:0];
                  ovf_set    = sum_add[SUM_W];
                  count_next = count_inc;
                  burst_ev   = (eff_mode == MODE_BURST);
               end
            end
            MODE_LPF: begin
               // Sum settles at sample times two to the shift, so gain stays one
               sum_next    = lpf_sum;
               filter_next = FILT_W'(lpf_sum >> ctrl2_reg.sum_shift_select);
               count_next  = count_inc;
               calc_ev     = 1'b1;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sum_reg        <= '0;
         count_reg      <= '0;
         filter_reg     <= '0;
         ovf_reg        <= 1'b0;
         burst_more_reg <= 1'b0;
      end else begin
         sum_reg    <= sum_next;
         count_reg  <= count_next;
         filter_reg <= filter_next;
         if (ctrl2_reg.sum_clear_command) begin
            ovf_reg <= 1'b0;
         end else if (ovf_set) begin
            ovf_reg <= 1'b1;
         end
         if (start_fire || !enable) begin
            burst_more_reg <= 1'b0;
         end else if (burst_ev) begin
            burst_more_reg <= 1'b1;
         end
      end
   end

   // Interrupts: sticky status, set wins over a same-cycle clear
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         stat_reg <= '0;
         ien_reg  <= '0;
         o_irq    <= 1'b0;
      end else begin
         stat_reg <= (stat_reg & ~(wr_clr ? wmerge[INT_W-1:0] : {INT_W{1'b0}}))
                     | {ovf_set & ~ovf_reg, calc_ev, done_fire};
         if (wr_ien) begin
            ien_reg <= wmerge[INT_W-1:0];
         end
         o_irq <= |(stat_reg & ien_reg);
      end
   end

   a_start_needs_enable: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_conv_start |-> $past(enable))
      else $error("conversion started while disabled");
   a_go_starts_conv: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (state_reg == ST_IDLE && enable && ctrl0_reg[CTRL0_GO_BIT]) |=> o_conv_start)
      else $error("go did not start a conversion");
   a_prev_sample_copy: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      start_fire |=> prev_reg == ($past(ctrl2_reg.previous_source_select)
                    ? $past(filter_reg) : {4'h0, $past(result_reg)}))
      else $error("previous sample copied from wrong source");
   a_clear_sum_state: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      ctrl2_reg.sum_clear_command |=> (sum_reg == '0 && count_reg == '0 && !ovf_reg))
      else $error("clear command left sum state");
   a_clear_bit_self: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (ctrl2_reg.sum_clear_command && !wr_ctrl2) |=> !ctrl2_reg.sum_clear_command)
      else $error("clear command bit not released");
   a_write_right_just: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (wr_result && !done_fire && wstrb_reg[0] && wstrb_reg[1])
      |=> result_reg == $past(wdata_reg[RES_W-1:0]))
      else $error("result write not stored right justified");
   a_left_read_shift: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_arvalid && o_arready && i_araddr == A_RESULT && !right_just)
      |=> o_rdata == {16'h0000, $past(result_reg), 4'h0})
      else $error("left justified read wrong");
   a_basic_keeps_sum: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (done_fire && eff_mode == MODE_BASIC && !ctrl2_reg.sum_clear_command)
      |=> $stable(sum_reg) && $stable(filter_reg))
      else $error("basic mode touched the sum");
   a_accum_adds: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (done_fire && eff_mode == MODE_ACCUM && !ctrl2_reg.sum_clear_command)
      |=> sum_reg == $past(sum_reg) + SUM_W'($past(i_conv_data)))
      else $error("accumulate did not add the sample");
   a_lpf_output: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (done_fire && eff_mode == MODE_LPF && !ctrl2_reg.sum_clear_command)
      |=> filter_reg == FILT_W'(sum_reg >> ctrl2_reg.sum_shift_select))
      else $error("filter output not sum over time constant");

endmodule : adcrc_top

`default_nettype wire

//--- sim/test_adc_result_compute_control.sv
// Testbench: registers, conversion starts, compute modes and interrupt of adcrc_top
`timescale 1ns/1ns
`default_nettype none
module test_adc_result_compute_control
   import adcrc_pkg::*;
();
   logic              i_clk_sys = 1'h0;
   logic              i_rst = 1'h1;
   logic [AXI_AW-1:0] i_awaddr = '0;
   logic [AXI_AW-1:0] i_araddr = '0;
   logic [31:0]       i_wdata = '0;
   logic [3:0]        i_wstrb = '0;
   logic              i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
   logic              i_arvalid = 1'h0, i_rready = 1'h0;
   logic              i_ext_trigger = 1'h0, i_conv_done = 1'h0;
   logic [RES_W-1:0]  i_conv_data = '0;
   logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic              o_conv_start, o_irq;
   logic [1:0]        o_bresp, o_rresp, rs;
   logic [31:0]       o_rdata, rv;
   int                err_total = 0, checks = 0, cyc = 0, starts = 0, used = 0;

   adcrc_top u_adcrc_top (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
      .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
      .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
      .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
      .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
      .i_ext_trigger(i_ext_trigger), .i_conv_done(i_conv_done), .i_conv_data(i_conv_data),
      .o_conv_start(o_conv_start), .o_irq(o_irq)
   );

   always #5 i_clk_sys = ~i_clk_sys;

   // Start pulses are counted so a wait never misses one that came early
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (o_conv_start === 1'h1) starts <= starts + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         close_out();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : tick

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out

   task automatic wr(input logic [9:0] ix, input logic [31:0] d, input logic [1:0] er);
      tick(1);
      i_awaddr <= {ix, 2'h0};
      i_wdata <= d;
      i_wstrb <= 4'hF;
      i_awvalid <= 1'h1;
      i_wvalid <= 1'h1;
      i_bready <= 1'h1;
      do begin
         tick(1);
         if (i_awvalid && o_awready) i_awvalid <= 1'h0;
         if (i_wvalid && o_wready) i_wvalid <= 1'h0;
      end while (o_bvalid !== 1'h1);
      i_bready <= 1'h0;
      chk("bresp", {30'h0, o_bresp}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [9:0] ix);
      tick(1);
      i_araddr <= {ix, 2'h0};
      i_arvalid <= 1'h1;
      i_rready <= 1'h1;
      do begin
         tick(1);
         if (i_arvalid && o_arready) i_arvalid <= 1'h0;
      end while (o_rvalid !== 1'h1);
      rv = o_rdata;
      rs = o_rresp;
      i_rready <= 1'h0;
   endtask : rd

   task automatic rc(input string nm, input logic [9:0] ix, input logic [31:0] e);
      rd(ix);
      chk(nm, rv, e);
      chk("rresp", {30'h0, rs}, {30'h0, RESP_OKAY});
   endtask : rc

   // Converter core answers a few cycles after each start pulse
   task automatic conv(input logic [RES_W-1:0] d);
      while (starts <= used) tick(1);
      used = used + 1;
      tick(3);
      i_conv_done <= 1'h1;
      i_conv_data <= d;
      tick(1);
      i_conv_done <= 1'h0;
      tick(3);
   endtask : conv

   task automatic go_conv(input logic [RES_W-1:0] d);
      wr(IDX_CTRL0, 32'h7, RESP_OKAY);
      conv(d);
   endtask : go_conv

   task automatic t_regs();
      rc("ctrl0", IDX_CTRL0, {24'h0, CTRL0_RESET});
      rc("ctrl2", IDX_CTRL2, {24'h0, CTRL2_RESET});
      rc("repeat", IDX_REPEAT, {24'h0, REPEAT_RESET});
      rc("status", IDX_STATUS, 32'h0);
      wr(10'h000, 32'hFF, RESP_SLVERR);
      rd(10'h000);
      chk("unmapped data", rv, 32'h0);
      chk("unmapped resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
      wr(IDX_CTRL2, 32'hE5, RESP_OKAY);
      rc("ctrl2", IDX_CTRL2, 32'hE5);
      wr(IDX_CTRL2, 32'h2D, RESP_OKAY);
      rc("ctrl2 clear", IDX_CTRL2, 32'h25);
      $display("test regs done");
   endtask : t_regs

   task automatic t_start();
      wr(IDX_CTRL0, 32'h6, RESP_OKAY);
      tick(20);
      chk("start off", starts, used);
      wr(IDX_CTRL0, 32'h4, RESP_OKAY);
      wr(IDX_CTRL0, 32'h5, RESP_OKAY);
      tick(10);
      chk("start idle", starts, used);
      go_conv(12'hABC);
      rc("right", IDX_RESULT, 32'hABC);
      rc("go clear", IDX_CTRL0, 32'h5);
      wr(IDX_CTRL0, 32'h1, RESP_OKAY);
      rc("left", IDX_RESULT, 32'hABC0);
      wr(IDX_RESULT, 32'h123, RESP_OKAY);
      rc("left wr", IDX_RESULT, 32'h1230);
      wr(IDX_CTRL0, 32'h5, RESP_OKAY);
      i_ext_trigger <= 1'h1;
      tick(1);
      i_ext_trigger <= 1'h0;
      conv(12'h111);
      rc("trigger", IDX_RESULT, 32'h111);
      wr(IDX_CTRL0, 32'hD, RESP_OKAY);
      conv(12'h222);
      conv(12'h333);
      wr(IDX_CTRL0, 32'h4, RESP_OKAY);
      tick(5);
      used = starts;
      rc("prev result", IDX_PREV, 32'h333);
      wr(IDX_CTRL0, 32'h5, RESP_OKAY);
      $display("test start done");
   endtask : t_start

   task automatic t_modes();
      wr(IDX_CTRL2, 32'h29, RESP_OKAY);
      go_conv(12'h100);
      go_conv(12'h300);
      rc("accum sum", IDX_SUM, 32'h400);
      rc("accum out", IDX_FILTER, 32'h100);
      rc("count", IDX_STATUS, 32'h200);
      wr(IDX_CTRL2, 32'h68, RESP_OKAY);
      rc("sum clr", IDX_SUM, 32'h0);
      rc("count clr", IDX_STATUS, 32'h0);
      go_conv(12'h7FF);
      rc("basic sum", IDX_SUM, 32'h0);
      rc("basic out", IDX_FILTER, 32'h100);
      wr(IDX_CTRL2, 32'h06, RESP_OKAY);
      go_conv(12'h7FF);
      rc("rsvd sum", IDX_SUM, 32'h0);
      wr(IDX_REPEAT, 32'h2, RESP_OKAY);
      wr(IDX_CTRL2, 32'h1A, RESP_OKAY);
      go_conv(12'h100);
      go_conv(12'h200);
      rc("avg", IDX_FILTER, 32'h180);
      wr(IDX_CTRL2, 32'h1B, RESP_OKAY);
      go_conv(12'h010);
      conv(12'h030);
      rc("burst", IDX_FILTER, 32'h20);
      wr(IDX_CTRL2, 32'h0C, RESP_OKAY);
      go_conv(12'h155);
      rc("lpf k0", IDX_FILTER, 32'h155);
      wr(IDX_CTRL2, 32'h1C, RESP_OKAY);
      go_conv(12'h100);
      go_conv(12'h100);
      rc("lpf k1", IDX_FILTER, 32'hC0);
      wr(IDX_CTRL2, 32'h80, RESP_OKAY);
      go_conv(12'h444);
      rc("prev filt", IDX_PREV, 32'hC0);
      $display("test modes done");
   endtask : t_modes

   task automatic t_irq();
      wr(IDX_INT_EN, 32'h0, RESP_OKAY);
      wr(IDX_INT_CLR, 32'h7, RESP_OKAY);
      rc("int stat", IDX_INT_STAT, 32'h0);
      go_conv(12'h001);
      rd(IDX_INT_STAT);
      chk("done flag", {31'h0, rv[INT_DONE_BIT]}, 32'h1);
      chk("irq masked", {31'h0, o_irq}, 32'h0);
      wr(IDX_INT_EN, 32'h1, RESP_OKAY);
      tick(2);
      chk("irq on", {31'h0, o_irq}, 32'h1);
      wr(IDX_INT_CLR, 32'h1, RESP_OKAY);
      tick(2);
      chk("irq off", {31'h0, o_irq}, 32'h0);
      $display("test irq done");
   endtask : t_irq

   // 257 full-scale samples carry out of the 20-bit sum exactly once
   task automatic t_ovf();
      wr(IDX_CTRL2, 32'h09, RESP_OKAY);
      wr(IDX_INT_CLR, 32'h7, RESP_OKAY);
      wr(IDX_CTRL0, 32'hD, RESP_OKAY);
      repeat (257) conv(12'hFFF);
      wr(IDX_CTRL0, 32'h4, RESP_OKAY);
      tick(5);
      used = starts;
      rc("ovf sum", IDX_SUM, 32'h80000EFF);
      rc("ovf flag", IDX_INT_STAT, 32'h7);
      wr(IDX_CTRL2, 32'h09, RESP_OKAY);
      rc("ovf clr", IDX_SUM, 32'h0);
      $display("test ovf done");
   endtask : t_ovf

   initial begin
      tick(16);
      i_rst <= 1'h0;
      t_regs();
      t_start();
      t_modes();
      t_irq();
      t_ovf();
      close_out();
   end
endmodule : test_adc_result_compute_control
`default_nettype wire
